// ==== src/msf_pkg.sv ====
// shared constants for the module status and flag supervisor
package msf_pkg;

  // clock rate and the time limits that shape counters
  localparam int CLK_MHZ            = 100;
  localparam int MGMT_INIT_MAX_MS   = 2000;
  localparam int MGMT_INIT_CYCLES   = MGMT_INIT_MAX_MS * 1000 * CLK_MHZ;
  localparam int RESET_MIN_US       = 10;
  localparam int RESET_MIN_CYCLES   = RESET_MIN_US * CLK_MHZ;
  localparam int INIT_CNT_W         = 28;
  localparam int RST_CNT_W          = 11;

  // axi4-lite geometry and responses
  localparam int ADDR_W             = 8;
  localparam int DATA_W             = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;

  // flag layout: rx los, tx fault, tx los, then auxiliary conditions
  localparam int NUM_AUX     = 4;
  localparam int NUM_FLAGS   = 3 + NUM_AUX;
  localparam int FL_RX_LOS   = 0;
  localparam int FL_TX_FAULT = 1;
  localparam int FL_TX_LOS   = 2;
  localparam logic [NUM_FLAGS-1:0] MASK_RESET = 7'h00;

  // control bits
  localparam int CTRL_W       = 3;
  localparam int CT_TX_DIS    = 0;
  localparam int CT_FAST_MODE = 1;
  localparam int CT_RX_DIS    = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // status layout above the live conditions
  localparam int ST_INIT = NUM_FLAGS;
  localparam int ST_IRQ  = NUM_FLAGS + 1;
  localparam int ST_LOS  = NUM_FLAGS + 2;

  // receive power in tenths of dbm, hysteresis thresholds
  localparam int PWR_W = 16;
  localparam logic signed [PWR_W-1:0] LOS_ASSERT_LVL   = 16'hffb0;
  localparam logic signed [PWR_W-1:0] LOS_DEASSERT_LVL = 16'hffba;

endpackage : msf_pkg

// ==== src/msf_sync.sv ====
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/100ps
`default_nettype none
module msf_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : msf_sync
`default_nettype wire

// ==== src/msf_los_detect.sv ====
// receive loss of signal with hysteresis on average power
`timescale 1ns/100ps
`default_nettype none
module msf_los_detect (
  input  wire logic                            aclk,
  input  wire logic                            rst_n,
  input  wire logic signed [msf_pkg::PWR_W-1:0] rx_power,
  output var  logic                            los_reg
);
  import msf_pkg::*;

  // the gap between levels keeps a noisy input from chattering
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      los_reg <= 1'b0;
    end else if (!los_reg && rx_power <= LOS_ASSERT_LVL) begin
      los_reg <= 1'b1;
    end else if (los_reg && rx_power >= LOS_DEASSERT_LVL) begin
      los_reg <= 1'b0;
    end
  end
endmodule : msf_los_detect
`default_nettype wire

// ==== src/msf_supervisor.sv ====
// status, flag, interrupt, squelch and disable supervisor with axi4-lite registers
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module msf_supervisor #(
  parameter int INIT_CYCLES = msf_pkg::MGMT_INIT_CYCLES
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [msf_pkg::ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output var  logic                             s_axi_awready,
  input  wire logic [msf_pkg::DATA_W-1:0]       s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output var  logic                             s_axi_wready,
  output var  logic [1:0]                       s_axi_bresp,
  output var  logic                             s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [msf_pkg::ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output var  logic                             s_axi_arready,
  output var  logic [msf_pkg::DATA_W-1:0]       s_axi_rdata,
  output var  logic [1:0]                       s_axi_rresp,
  output var  logic                             s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             module_reset_n,
  input  wire logic signed [msf_pkg::PWR_W-1:0] rx_power,
  input  wire logic                             tx_fault_in,
  input  wire logic                             tx_los_in,
  input  wire logic                             tx_disable_pin,
  input  wire logic [msf_pkg::NUM_AUX-1:0]      aux_cond_in,
  output var  logic                             module_interrupt_n,
  output var  logic                             management_init_window,
  output var  logic                             rx_los_out,
  output var  logic                             rx_output_enable,
  output var  logic                             tx_output_enable,
  output var  logic                             tx_squelch
);
  import msf_pkg::*;

  localparam int PIN_W = 4 + NUM_AUX;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and loss detection

  logic [PIN_W-1:0]         pin_s;
  logic signed [PWR_W-1:0]  pwr_s;
  logic                     rst_n;
  logic                     rx_los_s;

  msf_sync #(.W(PIN_W)) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({aux_cond_in, tx_disable_pin, tx_los_in, tx_fault_in, module_reset_n}),
    .sync_out (pin_s)
  );

  // power word may straddle a change for one sample; hysteresis absorbs it
  msf_sync #(.W(PWR_W)) u_pwr_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (rx_power),
    .sync_out (pwr_s)
  );

  msf_los_detect u_los (
    .aclk     (aclk),
    .rst_n    (rst_n),
    .rx_power (pwr_s),
    .los_reg  (rx_los_s)
  );

  logic                 mreset_n_s;
  logic                 tx_fault_s;
  logic                 tx_los_s;
  logic                 tx_dis_pin_s;
  logic [NUM_AUX-1:0]   aux_s;

  assign mreset_n_s   = pin_s[0];
  assign tx_fault_s   = pin_s[1];
  assign tx_los_s     = pin_s[2];
  assign tx_dis_pin_s = pin_s[3];
  assign aux_s        = pin_s[PIN_W-1:4];

  //////////////////////////////////////////////////////////////////////////////
  // module reset pin filter and init window

  logic [RST_CNT_W-1:0]  rst_cnt_reg;
  logic                  mod_rst_reg;
  logic [INIT_CNT_W-1:0] init_cnt_reg;
  logic                  init_busy_reg;

  // short glitches on the pin are ignored; a long enough low resets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_reg <= '0;
      mod_rst_reg <= 1'b0;
    end else if (mreset_n_s) begin
      rst_cnt_reg <= '0;
      mod_rst_reg <= 1'b0;
    end else begin
      if (rst_cnt_reg != RST_CNT_W'(RESET_MIN_CYCLES))
        rst_cnt_reg <= rst_cnt_reg + 1'b1;
      if (rst_cnt_reg >= RST_CNT_W'(RESET_MIN_CYCLES - 1))
        mod_rst_reg <= 1'b1;
    end
  end

  assign rst_n = aresetn & ~mod_rst_reg;

  // window reopens on power-on reset and once the reset pin has stayed low long enough; its count starts when the pin rises
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      init_cnt_reg  <= '0;
      init_busy_reg <= 1'b1;
    end else if (init_busy_reg) begin
      if (init_cnt_reg == INIT_CNT_W'(INIT_CYCLES - 1))
        init_busy_reg <= 1'b0;
      else
        init_cnt_reg <= init_cnt_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic                aw_full_reg;
  logic [ADDR_W-1:0]   aw_addr_reg;
  logic                w_full_reg;
  logic [CTRL_W+3:0]   w_data_reg;
  logic                w_strb_reg;
  logic                aw_take;
  logic                w_take;
  logic                wr_fire;
  logic                wr_ok;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take  = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wr_ok   = wr_fire & ~init_busy_reg & w_strb_reg;

  // address and data land in either order; response once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_full_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata[CTRL_W+3:0];
        w_strb_reg   <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg != OFS_FLAGS && aw_addr_reg != OFS_MASK &&
            aw_addr_reg != OFS_CTRL && aw_addr_reg != OFS_STATUS)
          s_axi_bresp <= RESP_DECERR;
        else if (init_busy_reg)
          s_axi_bresp <= RESP_SLVERR;
        else
          s_axi_bresp <= RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mask and control registers

  logic [NUM_FLAGS-1:0] mask_reg;
  logic [CTRL_W-1:0]    ctrl_reg;

  // only the low byte holds bits; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      mask_reg <= MASK_RESET;
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ok) begin
      if (aw_addr_reg == OFS_MASK)
        mask_reg <= w_data_reg[NUM_FLAGS-1:0];
      if (aw_addr_reg == OFS_CTRL)
        ctrl_reg <= w_data_reg[CTRL_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flags, read channel and clear on read

  logic [NUM_FLAGS-1:0] cond;
  logic [NUM_FLAGS-1:0] cond_prev_reg;
  logic [NUM_FLAGS-1:0] flags_reg;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic                 ar_take;
  logic                 rd_hit;
  logic [DATA_W-1:0]    rd_data;
  logic [1:0]           rd_resp;

  assign cond     = {aux_s, tx_los_s, tx_fault_s, rx_los_s};
  assign flag_set = cond & ~cond_prev_reg;
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign rd_hit   = ar_take & ~init_busy_reg & (s_axi_araddr == OFS_FLAGS);
  assign flag_clr = rd_hit ? flags_reg : '0;

  // read mux; status shows live state
  always_comb begin
    rd_data = '0;
    rd_resp = init_busy_reg ? RESP_SLVERR : RESP_OKAY;
    unique case (s_axi_araddr)
      OFS_FLAGS:  rd_data[NUM_FLAGS-1:0] = flags_reg;
      OFS_MASK:   rd_data[NUM_FLAGS-1:0] = mask_reg;
      OFS_CTRL:   rd_data[CTRL_W-1:0]    = ctrl_reg;
      OFS_STATUS: begin
        rd_data[NUM_FLAGS-1:0] = cond;
        rd_data[ST_INIT]       = init_busy_reg;
        rd_data[ST_IRQ]        = ~module_interrupt_n;
        rd_data[ST_LOS]        = rx_los_out;
      end
      default:    rd_resp = RESP_DECERR;
    endcase
    if (init_busy_reg)
      rd_data = '0;
  end

  // a new event in the clearing cycle survives: set wins
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      flags_reg     <= '0;
      cond_prev_reg <= '0;
    end else begin
      cond_prev_reg <= cond;
      flags_reg     <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  // one read at a time; address ready again after the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt, squelch and disable outputs

  // interrupt low while any unmasked flag stays latched
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      module_interrupt_n <= 1'b1;
    end else begin
      module_interrupt_n <= ~|(flags_reg & ~mask_reg);
    end
  end

  // both disable modes act in a cycle, well inside either limit
  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      management_init_window <= 1'b1;
      rx_los_out             <= 1'b0;
      rx_output_enable       <= 1'b0;
      tx_squelch             <= 1'b0;
      tx_output_enable       <= 1'b0;
    end else begin
      management_init_window <= init_busy_reg;
      rx_los_out             <= rx_los_s;
      rx_output_enable       <= ~rx_los_s & ~ctrl_reg[CT_RX_DIS];
      tx_squelch             <= tx_los_s;
      tx_output_enable       <= ~tx_los_s & ~ctrl_reg[CT_TX_DIS] & ~tx_dis_pin_s;
    end
  end

endmodule : msf_supervisor
`default_nettype wire

// ==== verification/msf_supervisor_properties.sv ====
// port-level assertions for the status and flag supervisor
`timescale 1ns/100ps
`default_nettype none
module msf_supervisor_properties (
  input wire logic                         aclk,
  input wire logic                         aresetn,
  input wire logic [msf_pkg::ADDR_W-1:0]   s_axi_araddr,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic [msf_pkg::DATA_W-1:0]   s_axi_rdata,
  input wire logic [1:0]                   s_axi_rresp,
  input wire logic                         s_axi_rvalid,
  input wire logic                         s_axi_rready,
  input wire logic                         tx_disable_pin,
  input wire logic                         tx_los_in,
  input wire logic                         module_interrupt_n,
  input wire logic                         management_init_window,
  input wire logic                         rx_los_out,
  input wire logic                         rx_output_enable,
  input wire logic                         tx_output_enable,
  input wire logic                         tx_squelch
);
  import msf_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // register bus answers
  rd_accept_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered one cycle after acceptance");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  // an okay answer proves the init window is over
  init_refuse_a: assert property ($rose(s_axi_rvalid) && s_axi_rresp == RESP_OKAY |-> !management_init_window)
    else $error("okay answer inside init window");
  unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_STATUS
    && !management_init_window |=> s_axi_rresp == RESP_DECERR)
    else $error("unmapped read not refused");
  // outputs against synced inputs, five cycles covers sync plus register
  tx_pin_off_a: assert property (tx_disable_pin [*5] |-> !tx_output_enable)
    else $error("tx output on while disable pin held");
  squelch_on_a: assert property (tx_los_in [*5] |-> tx_squelch)
    else $error("tx not squelched on input loss");
  squelch_off_a: assert property (!tx_los_in [*5] |-> !tx_squelch)
    else $error("tx squelch kept after input returned");
  rx_squelch_a: assert property (rx_los_out && $past(rx_los_out) |-> !rx_output_enable)
    else $error("rx output on during loss of signal");
  int_fall_c: cover property ($fell(module_interrupt_n));
  squelch_c: cover property ($rose(tx_squelch));
  init_done_c: cover property ($fell(management_init_window));
  rd_wait_c: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : msf_supervisor_properties
bind msf_supervisor msf_supervisor_properties msf_supervisor_properties_inst (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .tx_disable_pin, .tx_los_in, .module_interrupt_n,
  .management_init_window, .rx_los_out, .rx_output_enable, .tx_output_enable, .tx_squelch
);
`default_nettype wire

// ==== verification/msf_host_model.sv ====
// host controller model: axi4-lite master and module reset pin
`timescale 1ns/100ps
`default_nettype none
module msf_host_model (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready,
  output var  logic        module_reset_n,
  output var  logic        stuck
);
  bit rready_late; // a late sink makes the read data stand for an extra cycle
  // idle bus at time zero, reset pin released
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, stuck} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h00000;
    s_axi_wdata = 32'h0;
    module_reset_n = 1'b1;
  end
  // released payload is inverted so a stale value is never mistaken for live
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw, w, b;
    @(posedge aclk);
    n = 0;
    aw = 0;
    w = 0;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 64) begin
      @(posedge aclk);
      n++;
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!b) stuck <= 1'b1;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit b;
    @(posedge aclk);
    n = 0;
    b = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !rready_late;
    while (!b && n < 64) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
        b = 1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end else if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b1;
      end
    end
    if (!b) stuck <= 1'b1;
  endtask : axi_read
  // low pulse on the module reset pin, length in clock cycles
  task automatic pulse_reset(input int n);
    @(posedge aclk);
    module_reset_n <= 1'b0;
    repeat (n) @(posedge aclk);
    module_reset_n <= 1'b1;
  endtask : pulse_reset
endmodule : msf_host_model
`default_nettype wire

// ==== verification/msf_supervisor_bench.sv ====
// self-checking bench for the status and flag supervisor
`timescale 1ns/100ps
`default_nettype none
module msf_supervisor_bench;
  import msf_pkg::*;
  localparam int INIT_N = 50; // short init window keeps the run brief
  logic aclk, aresetn, tx_fault_in, tx_los_in, tx_disable_pin, stuck, module_reset_n;
  logic signed [15:0] rx_power;
  logic [3:0] aux_cond_in, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic module_interrupt_n, management_init_window, rx_los_out, rx_output_enable, tx_output_enable, tx_squelch;
  int errors, total_checks;
  msf_supervisor #(.INIT_CYCLES(INIT_N)) msf_supervisor_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .module_reset_n, .rx_power, .tx_fault_in, .tx_los_in, .tx_disable_pin, .aux_cond_in,
    .module_interrupt_n, .management_init_window, .rx_los_out, .rx_output_enable,
    .tx_output_enable, .tx_squelch);
  msf_host_model msf_host_model_inst (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .module_reset_n, .stuck);
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_data
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_data({30'h0, g}, {30'h0, e});
  endtask : chk_resp
  task automatic chk_pin(input logic g, input logic e);
    chk_data({31'h0, g}, {31'h0, e});
  endtask : chk_pin
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    msf_host_model_inst.axi_write(a, d, r);
    chk_resp(r, RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    msf_host_model_inst.axi_read(a, d, r);
    chk_resp(r, er);
    chk_data(d, e);
  endtask : rd
  // fixed latency: sync plus flag plus interrupt is four cycles, five through loss detection
  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask : settle
  task automatic wait_init();
    int n;
    n = 0;
    while (management_init_window !== 1'b0 && n < 4 * INIT_N) begin
      @(posedge aclk);
      n++;
    end
    if (management_init_window !== 1'b0) begin
      errors++;
      results();
    end
  endtask : wait_init
  // a hung bus transfer ends the run
  always @(posedge stuck) begin
    errors++;
    results();
  end
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    errors = 0;
    total_checks = 0;
    {aresetn, tx_fault_in, tx_los_in, tx_disable_pin, aux_cond_in} = 8'h00;
    rx_power = 16'sh0000;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_FLAGS, 32'h0, RESP_SLVERR);
    msf_host_model_inst.axi_write(OFS_MASK, 32'h1, r);
    chk_resp(r, RESP_SLVERR);
    wait_init();
    rd(OFS_MASK, 32'h0, RESP_OKAY);
    msf_host_model_inst.axi_read(8'h10, d, r);
    chk_resp(r, RESP_DECERR);
    msf_host_model_inst.axi_write(8'h10, 32'h1, r);
    chk_resp(r, RESP_DECERR);
    $display("test init done");
    // loss of signal, then a level inside the hysteresis band
    rx_power <= 16'shffa6;
    settle();
    chk_pin(rx_los_out, 1'b1);
    chk_pin(rx_output_enable, 1'b0);
    chk_pin(module_interrupt_n, 1'b0);
    // late rready makes the status word stand for a cycle
    msf_host_model_inst.rready_late = 1'b1;
    rd(OFS_STATUS, 32'h301, RESP_OKAY);
    msf_host_model_inst.rready_late = 1'b0;
    rx_power <= 16'shffb5;
    settle();
    chk_pin(rx_los_out, 1'b1);
    rx_power <= 16'shffc4;
    settle();
    chk_pin(rx_los_out, 1'b0);
    chk_pin(module_interrupt_n, 1'b0);
    rd(OFS_FLAGS, 32'h1, RESP_OKAY);
    settle();
    chk_pin(module_interrupt_n, 1'b1);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    $display("test rx loss done");
    // every other flag source in turn
    for (int i = 1; i < NUM_FLAGS; i++) begin
      {aux_cond_in, tx_los_in, tx_fault_in} <= 6'h01 << (i - 1);
      settle();
      chk_pin(module_interrupt_n, 1'b0);
      chk_pin(tx_squelch, i == FL_TX_LOS);
      rd(OFS_FLAGS, 32'h1 << i, RESP_OKAY);
      settle();
      chk_pin(module_interrupt_n, 1'b1);
      {aux_cond_in, tx_los_in, tx_fault_in} <= 6'h00;
      settle();
      chk_pin(tx_squelch, 1'b0);
    end
    $display("test flags done");
    wr(OFS_MASK, 32'h8);
    aux_cond_in <= 4'h1;
    settle();
    chk_pin(module_interrupt_n, 1'b1);
    wr(OFS_MASK, 32'h0);
    settle();
    chk_pin(module_interrupt_n, 1'b0);
    rd(OFS_FLAGS, 32'h8, RESP_OKAY);
    aux_cond_in <= 4'h0;
    $display("test mask done");
    // transmit disable in normal and fast mode, then receive disable
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, {30'h0, m[0], 1'b1});
      settle();
      chk_pin(tx_output_enable, 1'b0);
      rd(OFS_CTRL, {30'h0, m[0], 1'b1}, RESP_OKAY);
      wr(OFS_CTRL, {30'h0, m[0], 1'b0});
      settle();
      chk_pin(tx_output_enable, 1'b1);
    end
    wr(OFS_CTRL, 32'h4);
    settle();
    chk_pin(rx_output_enable, 1'b0);
    wr(OFS_CTRL, 32'h0);
    tx_disable_pin <= 1'b1;
    settle();
    chk_pin(tx_output_enable, 1'b0);
    chk_pin(rx_output_enable, 1'b1);
    tx_disable_pin <= 1'b0;
    $display("test disable done");
    // a short pulse is ignored, a long one restarts management
    wr(OFS_MASK, 32'h7f);
    msf_host_model_inst.pulse_reset(500);
    settle();
    chk_pin(management_init_window, 1'b0);
    rd(OFS_MASK, 32'h7f, RESP_OKAY);
    msf_host_model_inst.pulse_reset(1100);
    settle();
    chk_pin(management_init_window, 1'b1);
    wait_init();
    rd(OFS_MASK, 32'h0, RESP_OKAY);
    $display("test module reset done");
    results();
  end
endmodule : msf_supervisor_bench
`default_nettype wire
